// ==== inc/cell_balance_pkg.sv ====
// Constants and types for the cell balance sequencer.
// Assumes a 100 MHz clock and an AXI4-Lite register bus with 32-bit data.
package cell_balance_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned ON_STEP_S = 20;
    localparam longint unsigned ON_STEP_CYCLES = longint'(ON_STEP_S) * longint'(CLK_HZ);
    localparam int unsigned WAIT_UNIT_S = 1;
    localparam longint unsigned WAIT_UNIT_CYCLES = longint'(WAIT_UNIT_S) * longint'(CLK_HZ);
    localparam int unsigned WD_UNIT_S = 1;
    localparam longint unsigned WD_UNIT_CYCLES = longint'(WD_UNIT_S) * longint'(CLK_HZ);

    localparam int unsigned NUM_CELLS = 12;
    localparam int unsigned NUM_LOCS = 13;
    localparam int unsigned HALF_W = 14;
    localparam int unsigned CHARGE_W = 28;
    localparam int unsigned VOLT_W = 14;

    localparam logic [7:0] ADDR_SETUP = 8'h00;
    localparam logic [7:0] ADDR_PATTERN = 8'h04;
    localparam logic [7:0] ADDR_TIME = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_CELLS = 8'h14;
    localparam logic [7:0] ADDR_CHARGE = 8'h40;
    localparam logic [7:0] ADDR_CHARGE_LAST = 8'h9C;

    localparam int unsigned SETUP_MODE_LSB = 0;
    localparam int unsigned SETUP_WAIT_LSB = 2;
    localparam int unsigned SETUP_PTR_LSB = 5;
    localparam int unsigned SETUP_RUN_BIT = 9;
    localparam int unsigned TIME_WD_LSB = 0;
    localparam int unsigned TIME_ON_LSB = 7;
    localparam int unsigned STATUS_DONE_BIT = 0;
    localparam int unsigned STATUS_WDX_BIT = 1;
    localparam int unsigned STATUS_SLEEP_BIT = 2;
    localparam int unsigned CMD_ENABLE_BIT = 0;
    localparam int unsigned CMD_INHIBIT_BIT = 1;
    localparam int unsigned CMD_SLEEP_BIT = 2;
    localparam int unsigned CMD_WAKE_BIT = 3;

    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_MANUAL = 2'h1;
    localparam logic [1:0] MODE_TIMED = 2'h2;
    localparam logic [1:0] MODE_AUTO = 2'h3;
    localparam logic [3:0] FIRST_AUTO_LOC = 4'h1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ON = 4'h2,
        ST_SCAN = 4'h4,
        ST_WAIT = 4'h8
    } seq_state_e;

    typedef struct packed {
        logic done;
        logic [NUM_CELLS-1:0][VOLT_W-1:0] volts;
    } scan_result_s;
endpackage

// ==== rtl/cell_balance_sequencer.sv ====
// Cell balance sequencer: timed and autonomous balancing behind AXI4-Lite.
// Assumes a measurement unit that answers scan_req with scan_result.done.
// Behaviour
// R1: mode code 10 selects timed balancing
// R2: host sets pointer zero, writes pattern
// R3: on time is code times 20 s
// R4: run set restarts full on time
// R5: run clear stops outputs, resets timer
// R6: timed expiry sets done, clears run
// R7: no balancing asleep; sleep stops at once
// R8: watchdog on: sleep now, flag later
// R9: watchdog timeout stops, sleeps, flags
// R10: timed timer runs on during sleep
// R11: mode code 11 selects autonomous balancing
// R12: host fills locations from 1, zero ends
// R13: drive current location, then advance pointer
// R14: all-zero location wraps to location 1
// R15: each location lasts the on time
// R16: scan all, then wait between locations
// R17: zero-charge cells stop, others continue
// R18: autonomous completion sets done, clears run
// R19: host loads charge values before enable
// R20: run clear keeps charges; restart at 1
// R21: wake resumes held autonomous state
// R22: subtract measured value after on interval
// R23: twelve 28-bit charges in 14-bit halves
// R24: pattern bit k drives cell k+1
// R25: outputs off unless running, awake, moded
// R26: charge subtraction saturates at zero
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cell_balance_sequencer #(
    parameter int unsigned ON_STEP_CYCLES = 32'(cell_balance_pkg::ON_STEP_CYCLES),
    parameter int unsigned WAIT_UNIT_CYCLES = 32'(cell_balance_pkg::WAIT_UNIT_CYCLES),
    parameter int unsigned WD_UNIT_CYCLES = 32'(cell_balance_pkg::WD_UNIT_CYCLES)
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire cell_balance_pkg::scan_result_s scan_result,
    output logic scan_req,
    output logic [11:0] balance_out
);
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] waitc;
        logic [3:0] ptr;
        logic run;
        logic [12:0][11:0] pat;
        logic [6:0] ontime;
        logic [6:0] wdcode;
        logic done;
        logic wdx;
        logic asleep;
        logic [11:0][27:0] charge;
        cell_balance_pkg::seq_state_e st;
        logic [31:0] pre;
        logic [6:0] steps;
        logic [31:0] wdpre;
        logic [6:0] wdsec;
        logic aw_full;
        logic [7:0] awa;
        logic w_full;
        logic [31:0] wd;
        logic [3:0] ws;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [11:0] bal;
        logic scan_req;
    } state_s;

    state_s s;
    state_s next_s;
    logic wr;
    logic start;
    logic stop;
    logic wd_fire;
    logic [31:0] v;

    function automatic logic [11:0] live(state_s t);
        logic [11:0] m;
        m = '0;
        for (int i = 0; i < 12; i++) begin
            m[i] = |t.charge[i];
        end
        return m;
    endfunction

    function automatic logic [11:0] loc(state_s t, logic [3:0] p);
        return (p < 4'(cell_balance_pkg::NUM_LOCS)) ? t.pat[p] : 12'h000;
    endfunction

    function automatic logic is_charge(logic [7:0] a);
        return a >= cell_balance_pkg::ADDR_CHARGE && a <= cell_balance_pkg::ADDR_CHARGE_LAST;
    endfunction

    function automatic logic mapped(logic [7:0] a);
        return a <= cell_balance_pkg::ADDR_CELLS || is_charge(a);
    endfunction

    function automatic logic [31:0] rd(state_s t, logic [7:0] a);
        logic [31:0] r;
        logic [4:0] idx;
        r = '0;
        idx = 5'((a - cell_balance_pkg::ADDR_CHARGE) >> 2);
        unique case (a)
            cell_balance_pkg::ADDR_SETUP: r = {22'h0, t.run, t.ptr, t.waitc, t.mode};
            cell_balance_pkg::ADDR_PATTERN: r = {20'h0, loc(t, t.ptr)};
            cell_balance_pkg::ADDR_TIME: r = {18'h0, t.ontime, t.wdcode};
            cell_balance_pkg::ADDR_STATUS: r = {29'h0, t.asleep, t.wdx, t.done};
            cell_balance_pkg::ADDR_CELLS: r = {20'h0, t.bal};
            default: begin
                if (is_charge(a)) begin
                    r = {18'h0, t.charge[idx[4:1]][idx[0]*14 +: 14]}; // R23
                end
            end
        endcase
        return r;
    endfunction

    always_comb begin
        logic [31:0] m;
        logic [31:0] unit;
        logic [4:0] idx;
        logic [3:0] np;
        logic kick;
        logic clr_done;
        logic clr_wdx;
        logic slp;
        logic wak;
        m = '0;
        unit = '0;
        idx = '0;
        np = '0;
        kick = 1'b0;
        clr_done = 1'b0;
        clr_wdx = 1'b0;
        slp = 1'b0;
        wak = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        wd_fire = 1'b0;
        v = '0;
        next_s = s;
        next_s.scan_req = 1'b0;
        wr = s.aw_full && s.w_full && !s.bvalid;
        if (awvalid && s.awready) begin
            next_s.aw_full = 1'b1;
            next_s.awa = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_full = 1'b1;
            next_s.wd = wdata;
            next_s.ws = wstrb;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            kick = 1'b1;
            next_s.rvalid = 1'b1;
            next_s.rdata = rd(s, araddr);
            next_s.rresp = mapped(araddr) ? cell_balance_pkg::RESP_OKAY
                                          : cell_balance_pkg::RESP_SLVERR;
        end
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{s.ws[b]}};
        end
        if (s.awa == cell_balance_pkg::ADDR_STATUS || s.awa == cell_balance_pkg::ADDR_CMD) begin
            v = s.wd & m;
        end else begin
            v = (rd(s, s.awa) & ~m) | (s.wd & m);
        end
        idx = 5'((s.awa - cell_balance_pkg::ADDR_CHARGE) >> 2);
        if (wr) begin
            kick = 1'b1;
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = mapped(s.awa) ? cell_balance_pkg::RESP_OKAY
                                         : cell_balance_pkg::RESP_SLVERR;
            unique case (s.awa)
                cell_balance_pkg::ADDR_SETUP: begin
                    next_s.mode = v[cell_balance_pkg::SETUP_MODE_LSB +: 2]; // R1 R11
                    next_s.waitc = v[cell_balance_pkg::SETUP_WAIT_LSB +: 3];
                    next_s.ptr = v[cell_balance_pkg::SETUP_PTR_LSB +: 4];
                    start = v[cell_balance_pkg::SETUP_RUN_BIT];
                    stop = !v[cell_balance_pkg::SETUP_RUN_BIT];
                end
                cell_balance_pkg::ADDR_PATTERN: begin
                    if (s.ptr < 4'(cell_balance_pkg::NUM_LOCS)) begin
                        next_s.pat[s.ptr] = v[11:0];
                    end
                end
                cell_balance_pkg::ADDR_TIME: begin
                    next_s.ontime = v[cell_balance_pkg::TIME_ON_LSB +: 7];
                    next_s.wdcode = v[cell_balance_pkg::TIME_WD_LSB +: 7];
                end
                cell_balance_pkg::ADDR_STATUS: begin
                    clr_done = v[cell_balance_pkg::STATUS_DONE_BIT];
                    clr_wdx = v[cell_balance_pkg::STATUS_WDX_BIT];
                end
                cell_balance_pkg::ADDR_CMD: begin
                    start = v[cell_balance_pkg::CMD_ENABLE_BIT];
                    stop = v[cell_balance_pkg::CMD_INHIBIT_BIT];
                    slp = v[cell_balance_pkg::CMD_SLEEP_BIT];
                    wak = v[cell_balance_pkg::CMD_WAKE_BIT];
                end
                default: begin
                    if (is_charge(s.awa)) begin
                        next_s.charge[idx[4:1]][idx[0]*14 +: 14] = v[13:0]; // R23
                    end
                end
            endcase
        end
        next_s.awready = !next_s.aw_full && !next_s.bvalid;
        next_s.wready = !next_s.w_full && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
        if (clr_done) begin
            next_s.done = 1'b0;
        end
        if (clr_wdx) begin
            next_s.wdx = 1'b0;
        end
        if (kick) begin
            next_s.wdpre = '0;
            next_s.wdsec = '0;
        end else if (s.wdcode != 7'h00 && s.wdsec != s.wdcode) begin
            if (s.wdpre == WD_UNIT_CYCLES - 1) begin
                next_s.wdpre = '0;
                next_s.wdsec = s.wdsec + 7'h01;
                wd_fire = (s.wdsec + 7'h01) == s.wdcode;
            end else begin
                next_s.wdpre = s.wdpre + 32'h1;
            end
        end
        if (wd_fire) begin
            next_s.wdx = 1'b1; // R8 R9
            next_s.asleep = 1'b1; // R9
        end
        if (slp) begin
            next_s.asleep = 1'b1; // R7 R8
        end else if (wak) begin
            next_s.asleep = 1'b0; // R10 R21
        end
        unit = (s.st == cell_balance_pkg::ST_WAIT) ? WAIT_UNIT_CYCLES : ON_STEP_CYCLES;
        if (stop) begin
            next_s.run = 1'b0; // R5 R20
            next_s.st = cell_balance_pkg::ST_IDLE;
            next_s.pre = '0;
            next_s.steps = '0;
        end
        if (start) begin
            next_s.run = 1'b1; // R4
            next_s.st = cell_balance_pkg::ST_ON;
            next_s.pre = '0;
            next_s.steps = next_s.ontime; // R3 R4
            if (next_s.mode == cell_balance_pkg::MODE_AUTO) begin
                next_s.ptr = cell_balance_pkg::FIRST_AUTO_LOC; // R20
            end
        end else if (!stop && s.run && (s.mode == cell_balance_pkg::MODE_TIMED
                || (s.mode == cell_balance_pkg::MODE_AUTO && !s.asleep))) begin
            unique case (s.st)
                cell_balance_pkg::ST_ON, cell_balance_pkg::ST_WAIT: begin
                    if (s.steps == 7'h00) begin
                        if (s.mode == cell_balance_pkg::MODE_TIMED) begin
                            if (s.ontime != 7'h00) begin
                                next_s.done = 1'b1; // R6 R10
                                next_s.run = 1'b0;
                                next_s.st = cell_balance_pkg::ST_IDLE;
                            end
                        end else if (s.st == cell_balance_pkg::ST_ON) begin
                            next_s.st = cell_balance_pkg::ST_SCAN; // R15 R16
                            next_s.scan_req = 1'b1;
                        end else begin
                            np = (s.ptr >= 4'hC) ? cell_balance_pkg::FIRST_AUTO_LOC
                                                 : s.ptr + 4'h1;
                            if (loc(s, np) == 12'h000) begin
                                np = cell_balance_pkg::FIRST_AUTO_LOC; // R14
                            end
                            next_s.ptr = np; // R13
                            next_s.st = cell_balance_pkg::ST_ON;
                            next_s.steps = s.ontime; // R15
                            next_s.pre = '0;
                        end
                    end else if (s.pre == unit - 1) begin
                        next_s.pre = '0;
                        next_s.steps = s.steps - 7'h01; // R3
                    end else begin
                        next_s.pre = s.pre + 32'h1;
                    end
                end
                cell_balance_pkg::ST_SCAN: begin
                    if (scan_result.done) begin
                        for (int i = 0; i < 12; i++) begin
                            if (loc(s, s.ptr)[i]) begin
                                next_s.charge[i] = (s.charge[i] > 28'(scan_result.volts[i]))
                                    ? s.charge[i] - 28'(scan_result.volts[i]) : '0; // R22 R26
                            end
                        end
                        if (live(next_s) == 12'h000) begin
                            next_s.done = 1'b1; // R18
                            next_s.run = 1'b0;
                            next_s.st = cell_balance_pkg::ST_IDLE;
                        end else begin
                            next_s.st = cell_balance_pkg::ST_WAIT; // R16
                            next_s.pre = '0;
                            next_s.steps = (s.waitc == 3'h0) ? 7'h00
                                : 7'(7'h01 << (s.waitc - 3'h1));
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        next_s.bal = 12'h000;
        if (next_s.run && !next_s.asleep && next_s.st == cell_balance_pkg::ST_ON
                && next_s.mode != cell_balance_pkg::MODE_OFF) begin // R7 R25
            if (next_s.mode == cell_balance_pkg::MODE_AUTO) begin
                next_s.bal = loc(next_s, next_s.ptr) & live(next_s); // R13 R17 R24
            end else begin
                next_s.bal = next_s.pat[0]; // R24
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.st <= cell_balance_pkg::ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign scan_req = s.scan_req;
    assign balance_out = s.bal;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_off_unless_run: assert property (!s.run || s.mode == 2'h0 |-> balance_out == 12'h000) // R25
        else $error("balance outputs on while not running");
    a_sleep_no_drive: assert property (s.asleep |-> balance_out == 12'h000) // R7
        else $error("balance outputs on while asleep");
    a_done_clears_run: assert property ($rose(s.done) |-> !s.run // R6
            && s.st == cell_balance_pkg::ST_IDLE)
        else $error("done flag set while still running");
    a_stop_resets_timer: assert property (stop && !start |=> !s.run && s.pre == 32'h0 // R5
            && s.steps == 7'h00 && balance_out == 12'h000)
        else $error("stop left timer or outputs active");
    a_start_full_time: assert property (start |=> s.run && s.st == cell_balance_pkg::ST_ON // R4
            && s.steps == s.ontime && s.pre == 32'h0)
        else $error("start did not load full on time");
    a_auto_drive_loc: assert property (s.run && s.mode == 2'h3 && !s.asleep // R13
            && s.st == cell_balance_pkg::ST_ON |-> balance_out == (loc(s, s.ptr) & live(s)))
        else $error("auto outputs differ from current location");
    a_scan_after_on: assert property (s.run && s.mode == 2'h3 && !s.asleep && !stop // R16
            && !start && s.st == cell_balance_pkg::ST_ON && s.steps == 7'h00
            |=> scan_req && s.st == cell_balance_pkg::ST_SCAN ##1 !scan_req)
        else $error("no single scan request after on interval");
    a_wrap_ptr: assert property (s.st == cell_balance_pkg::ST_WAIT // R14
            && $past(s.st) == cell_balance_pkg::ST_WAIT ##1 s.st == cell_balance_pkg::ST_ON
            |-> s.ptr == 4'h1 || loc(s, s.ptr) != 12'h000)
        else $error("pointer stopped on an empty location");
    a_wd_expire: assert property (wd_fire |=> s.asleep && s.wdx && balance_out == 12'h000) // R9
        else $error("watchdog expiry did not sleep and flag");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before taken");

    c_timed_done: cover property (s.mode == 2'h2 ##1 $rose(s.done));
    c_auto_done: cover property (s.mode == 2'h3 && s.st == cell_balance_pkg::ST_SCAN
            ##1 $rose(s.done));
    c_auto_wrap: cover property (s.st == cell_balance_pkg::ST_WAIT
            ##1 s.ptr == 4'h1 && s.st == cell_balance_pkg::ST_ON);
    c_wd_fire: cover property (wd_fire);
endmodule
`default_nettype wire

// ==== testbench/meas_unit_model.sv ====
// Model of the measurement unit that answers full measurement passes.
// Assumes scan_req is a one-cycle request pulse from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module meas_unit_model #(
    parameter int unsigned DELAY = 6,
    parameter logic [13:0] VOLT = 14'h0010
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scan_req,
    output var cell_balance_pkg::scan_result_s scan_result
);
    int cnt;
    // Answers each pass after a delay; volts toggle outside the answer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            scan_result <= '0;
        end else begin
            scan_result.done <= (cnt == 1);
            for (int i = 0; i < 12; i++) begin
                scan_result.volts[i] <= (cnt == 1) ? VOLT : ~scan_result.volts[i];
            end
            if (scan_req) begin
                cnt <= DELAY;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/test_cell_balance_sequencer.sv ====
// Self-checking bench for the cell balance sequencer.
// Assumes the measurement unit model answers scan requests.
`timescale 1ns/1ps
`default_nettype none
module test_cell_balance_sequencer;
    logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, scan_req;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [11:0] balance_out, seen;
    logic watch;
    cell_balance_pkg::scan_result_s scan_result;
    int err_count, checks_done, cycles;

    cell_balance_sequencer #(.ON_STEP_CYCLES(20), .WAIT_UNIT_CYCLES(5),
        .WD_UNIT_CYCLES(50)) DUT (.clk(clk), .nrst(nrst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .scan_result(scan_result), .scan_req(scan_req), .balance_out(balance_out));
    meas_unit_model MEAS (.clk(clk), .nrst(nrst), .scan_req(scan_req),
        .scan_result(scan_result));

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (watch) seen <= seen | balance_out;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid);
        // Late bready lets the response stand one cycle unanswered
        bready <= 1;
        @(posedge clk);
        rs = bresp;
        bready <= 0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 0;
    endtask

    task automatic t_reset_map();
        rdr(8'h00);
        check(rd, 32'h0);
        rdr(8'h0C);
        check(rd, 32'h0);
        rdr(8'hFC);
        check(rd, 32'h0);
        check(32'(rs), 32'h2);
        wr(8'hF8, 32'h1);
        check(rs, 2'h2);
    endtask
    task automatic t_timed();
        wr(8'h00, 32'h002);
        wr(8'h04, 32'h240);
        wr(8'h08, 32'h100);
        wr(8'h00, 32'h202);
        check(balance_out, 12'h240);
        repeat (30) @(posedge clk);
        rdr(8'h00);
        check(rd[9], 1'b1);
        repeat (15) @(posedge clk);
        rdr(8'h00);
        check(rd, 32'h002);
        rdr(8'h0C);
        check(rd, 32'h1);
        check(balance_out, 12'h0);
        wr(8'h0C, 32'h1);
    endtask
    task automatic t_cmds();
        wr(8'h10, 32'h1);
        check(balance_out, 12'h240);
        wr(8'h10, 32'h2);
        check(balance_out, 12'h0);
        rdr(8'h00);
        check(rd, 32'h002);
        wr(8'h10, 32'h1);
        wr(8'h10, 32'h4);
        rdr(8'h0C);
        check(rd, 32'h4);
        check(32'(balance_out), 32'h0);
        wr(8'h10, 32'h8);
        check(balance_out, 12'h240);
        wr(8'h10, 32'h4);
        repeat (50) @(posedge clk);
        wr(8'h10, 32'h8);
        rdr(8'h0C);
        check(rd, 32'h1);
        check(32'(balance_out), 32'h0);
        wr(8'h0C, 32'h1);
        wr(8'h00, 32'h201);
        check(balance_out, 12'h240);
        wr(8'h00, 32'h001);
        check(balance_out, 12'h0);
    endtask
    task automatic t_auto();
        wr(8'h00, 32'h027);
        wr(8'h04, 32'h555);
        wr(8'h00, 32'h047);
        wr(8'h04, 32'hAAA);
        wr(8'h00, 32'h067);
        wr(8'h04, 32'h000);
        wr(8'h08, 32'h080);
        wr(8'h40, 32'h10);
        wr(8'h48, 32'h18);
        wr(8'h4C, 32'h0);
        seen <= 12'h0;
        watch <= 1;
        wr(8'h00, 32'h227);
        check(balance_out, 12'h001);
        rdr(8'h00);
        for (int i = 0; i < 60 && rd[9] !== 1'b0; i++) begin
            repeat (5) @(posedge clk);
            rdr(8'h00);
        end
        watch <= 0;
        check(rd[9], 1'b0);
        check(seen, 12'h003);
        rdr(8'h0C);
        check(rd, 32'h1);
        rdr(8'h48);
        check(rd, 32'h0);
        rdr(8'h40);
        check(rd, 32'h0);
        wr(8'h48, 32'h30);
        wr(8'h00, 32'h227);
        check(balance_out, 12'h0);
        repeat (30) @(posedge clk);
        wr(8'h00, 32'h027);
        rdr(8'h48);
        check(rd, 32'h30);
        wr(8'h00, 32'h227);
        repeat (40) @(posedge clk);
        check(balance_out, 12'h002);
        wr(8'h10, 32'h4);
        check(balance_out, 12'h0);
        wr(8'h10, 32'h8);
        check(balance_out, 12'h002);
        wr(8'h10, 32'h2);
    endtask
    task automatic t_watchdog();
        wr(8'h08, 32'h001);
        repeat (60) @(posedge clk);
        rdr(8'h0C);
        check(rd[2:1], 2'h3);
        check(balance_out, 12'h0);
    endtask

    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready, watch} = '0;
        {awaddr, araddr, wdata, seen, rd, rs} = '0;
        wstrb = 4'hF;
        err_count = 0;
        checks_done = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        t_reset_map();
        t_timed();
        t_cmds();
        t_auto();
        t_watchdog();
        tally_and_finish();
    end
endmodule
`default_nettype wire
